// ### design/abc_regs.sv
`timescale 1ns/10ps
// What this block does
// - Block-enable register at 03h resets to zero; bit 0 enables zero-crossing detector.
// - Bit 1 of 03h enables first reference block; readable and writable.
// - Bit 2 of 03h enables second reference block; readable and writable.
// - Bit 3 of 03h set runs the power-amp output stage normally.
// - Bit 3 of 03h clear puts the power-amp stage in high impedance.
// - Register 04h resets to zero; bit 0 enables transmit calibration.
// - Bit 1 of 04h is read/write and enables receive calibration.
// - Bit 2 of 04h is read/write and enables transmit gain-amp calibration.
// - Bit 3 of 04h picks filter band: 0 lowest, 1 upper three.
// - Bit 6 of 04h is read-only transmit-ready status.
// - Bit 7 of 04h is read-only receive-ready status.
// - Register 05h defaults to 01h; bit 5 enables thermal flag latching.
// - Bit 6 of 05h enables overcurrent flag latching; readable and writable.
// - Frame is read/write bit, six-bit address, then eight data bits.
// - Sender changes data on falling clock edge; receiver captures on rising edge.
// - Overload flags latch high until reset; writing zero clears them.
// - Writing 101 to soft-reset bits restores registers 03h and 05h to defaults.
module abc_regs
  import abc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic tx_ready_in,
  input wire logic rx_ready_in,
  input wire logic thermal_overload_in,
  input wire logic overcurrent_in,
  output logic zero_cross_detector_enable,
  output logic reference_one_enable,
  output logic reference_two_enable,
  output logic power_amp_stage_enable,
  output logic power_amp_stage_hiz,
  output logic tx_calibrate,
  output logic rx_calibrate,
  output logic transmit_gain_amp_calibrate,
  output logic filter_band_select,
  output logic thermal_flag,
  output logic overcurrent_flag
);

  // ========================================================================
  // Input synchronisation and serial engine
  // ========================================================================

  logic [SY_W-1:0] raw_in;
  logic [SY_W-1:0] sy;

  abc_frame_if bus ();

  // Every pin input, the serial clock included, is sampled by the core clock.
  always_comb begin
    raw_in = SY_RST;
    raw_in[SY_SCLK] = sclk;
    raw_in[SY_CS] = cs_n;
    raw_in[SY_MOSI] = mosi;
    raw_in[SY_TXRDY] = tx_ready_in;
    raw_in[SY_RXRDY] = rx_ready_in;
    raw_in[SY_THERM] = thermal_overload_in;
    raw_in[SY_OCUR] = overcurrent_in;
  end

  abc_sync #(
    .W(SY_W),
    .RST(SY_RST)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(raw_in),
    .sync_out(sy)
  );

  abc_serial u_serial (
    .clk(clk),
    .arst_n(arst_n),
    .sclk_s(sy[SY_SCLK]),
    .cs_n_s(sy[SY_CS]),
    .mosi_s(sy[SY_MOSI]),
    .bus(bus.engine),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  // ========================================================================
  // Register file
  // ========================================================================

  logic [DATA_W-1:0] blk_q, blk_d;
  logic [DATA_W-1:0] cal_q, cal_d;
  logic [DATA_W-1:0] ovl_q, ovl_d;
  logic tflag_q, tflag_d;
  logic iflag_q, iflag_d;
  logic hiz_q, hiz_d;
  logic wr_blk, wr_cal, wr_ovl, wr_flg;
  logic soft_rst;

  // Address decode of a completed write frame.
  always_comb begin
    wr_blk = bus.wr_stb && (bus.addr == OFS_BLOCK);
    wr_cal = bus.wr_stb && (bus.addr == OFS_CAL);
    wr_ovl = bus.wr_stb && (bus.addr == OFS_OVL);
    wr_flg = bus.wr_stb && (bus.addr == OFS_FLAGS);
    soft_rst = wr_flg && (bus.wdata[KEY_MSB:KEY_LSB] == SOFT_RESET_KEY);
  end

  // Next values; only the writable fields take the written byte.
  always_comb begin
    blk_d = blk_q;
    cal_d = cal_q;
    ovl_d = ovl_q;
    if (wr_blk) begin
      blk_d = (blk_q & ~BLOCK_WMASK) | (bus.wdata & BLOCK_WMASK);
    end
    if (wr_cal) begin
      cal_d = (cal_q & ~CAL_WMASK) | (bus.wdata & CAL_WMASK);
    end
    if (wr_ovl) begin
      ovl_d = (ovl_q & ~OVL_WMASK) | (bus.wdata & OVL_WMASK);
    end
    // The calibration register is not among those the key restores.
    if (soft_rst) begin
      blk_d = BLOCK_RST;
      ovl_d = OVL_RST;
    end
    hiz_d = ~blk_d[BIT_PA];
  end

  // Overload flags: an event in the same cycle as a clearing write wins.
  always_comb begin
    tflag_d = tflag_q;
    iflag_d = iflag_q;
    if (wr_flg && !bus.wdata[BIT_TFLAG]) begin
      tflag_d = 1'b0;
    end
    if (wr_flg && !bus.wdata[BIT_IFLAG]) begin
      iflag_d = 1'b0;
    end
    if (sy[SY_THERM] && ovl_q[BIT_TEN]) begin
      tflag_d = 1'b1;
    end
    if (sy[SY_OCUR] && ovl_q[BIT_IEN]) begin
      iflag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blk_q <= BLOCK_RST;
      cal_q <= CAL_RST;
      ovl_q <= OVL_RST;
      tflag_q <= 1'b0;
      iflag_q <= 1'b0;
      hiz_q <= 1'b1;
    end else begin
      blk_q <= blk_d;
      cal_q <= cal_d;
      ovl_q <= ovl_d;
      tflag_q <= tflag_d;
      iflag_q <= iflag_d;
      hiz_q <= hiz_d;
    end
  end

  // ========================================================================
  // Read multiplexer
  // ========================================================================

  // Combinational so the engine can load the byte one cycle after the address.
  // Unmapped addresses and the write-only key bits read as zero.
  always_comb begin
    bus.rdata = ZERO_BYTE;
    if (bus.addr == OFS_BLOCK) begin
      bus.rdata = blk_q;
    end else if (bus.addr == OFS_CAL) begin
      bus.rdata = cal_q;
      bus.rdata[BIT_TXRDY] = sy[SY_TXRDY];
      bus.rdata[BIT_RXRDY] = sy[SY_RXRDY];
    end else if (bus.addr == OFS_OVL) begin
      bus.rdata = ovl_q;
    end else if (bus.addr == OFS_FLAGS) begin
      bus.rdata[BIT_TFLAG] = tflag_q;
      bus.rdata[BIT_IFLAG] = iflag_q;
    end
  end

  // ========================================================================
  // Control outputs, each taken straight from a register bit
  // ========================================================================

  assign zero_cross_detector_enable = blk_q[BIT_ZERO_CROSS];
  assign reference_one_enable = blk_q[BIT_REF_ONE];
  assign reference_two_enable = blk_q[BIT_REF_TWO];
  assign power_amp_stage_enable = blk_q[BIT_PA];
  assign power_amp_stage_hiz = hiz_q;
  assign tx_calibrate = cal_q[BIT_TXCAL];
  assign rx_calibrate = cal_q[BIT_RXCAL];
  assign transmit_gain_amp_calibrate = cal_q[BIT_PGACAL];
  assign filter_band_select = cal_q[BIT_BAND];
  assign thermal_flag = tflag_q;
  assign overcurrent_flag = iflag_q;

endmodule

// ### design/abc_serial.sv
`timescale 1ns/10ps
// ==========================================================================
// Serial frame engine: command, address and data on a sampled clock.
// ==========================================================================
module abc_serial
  import abc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk_s,
  input wire logic cs_n_s,
  input wire logic mosi_s,
  abc_frame_if.engine bus,
  output logic miso,
  output logic miso_oe
);

  abc_phase_t ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic [6:0] cmd_q, cmd_d;
  logic [7:0] wdata_q, wdata_d;
  logic sclk_prev_q, sclk_prev_d;
  logic load_q, load_d;
  logic wr_q, wr_d;
  logic miso_d, miso_oe_d;
  logic rise, fall;

  // Edges are found on the synchronised copy, so each costs a few cycles of latency.
  assign rise = sclk_s & ~sclk_prev_q;
  assign fall = ~sclk_s & sclk_prev_q;

  assign bus.wr_stb = wr_q;
  assign bus.addr = cmd_q[ADDR_W-1:0];
  assign bus.wdata = wdata_q;

  // Frame sequencer; a raised select aborts any frame at once.
  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    sclk_prev_d = sclk_s;
    load_d = 1'b0;
    wr_d = 1'b0;
    miso_d = miso;
    miso_oe_d = miso_oe;
    if (cs_n_s) begin
      ph_d = PH_IDLE;
      cnt_d = CNT_ZERO;
      miso_d = 1'b0;
      miso_oe_d = 1'b0;
    end else begin
      unique case (ph_q)
        PH_IDLE: begin
          ph_d = PH_CMD;
          cnt_d = CNT_ZERO;
          tx_d = ZERO_BYTE;
          miso_oe_d = 1'b1;
        end
        PH_CMD: begin
          if (rise) begin
            rx_d = {rx_q[6:0], mosi_s};
            cnt_d = cnt_q + CNT_ONE;
            if (cnt_q == CNT_CMD_LAST) begin
              cmd_d = {rx_q[5:0], mosi_s};
              load_d = 1'b1;
              ph_d = PH_DATA;
            end
          end
        end
        PH_DATA: begin
          // Address is settled one cycle after capture, so read data load here.
          if (load_q && cmd_q[ADDR_W]) begin
            tx_d = bus.rdata;
          end
          if (fall) begin
            miso_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
          end
          if (rise) begin
            rx_d = {rx_q[6:0], mosi_s};
            cnt_d = cnt_q + CNT_ONE;
            if (cnt_q == CNT_FRAME_LAST) begin
              wdata_d = {rx_q[6:0], mosi_s};
              wr_d = ~cmd_q[ADDR_W];
              ph_d = PH_DONE;
            end
          end
        end
        PH_DONE: begin
          // Clocks past the last data bit are ignored until select rises.
          if (fall) begin
            miso_d = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= PH_IDLE;
      cnt_q <= CNT_ZERO;
      rx_q <= ZERO_BYTE;
      tx_q <= ZERO_BYTE;
      cmd_q <= 7'h00;
      wdata_q <= ZERO_BYTE;
      sclk_prev_q <= 1'b0;
      load_q <= 1'b0;
      wr_q <= 1'b0;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
      sclk_prev_q <= sclk_prev_d;
      load_q <= load_d;
      wr_q <= wr_d;
      miso <= miso_d;
      miso_oe <= miso_oe_d;
    end
  end

endmodule

// ### design/abc_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// Two flip-flop synchroniser for a vector of independent levels.
// ==========================================================================
module abc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  // Only the second stage is visible; the first stage feeds nothing else.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST;
      sync_out <= RST;
    end else begin
      meta_q <= meta_d;
      sync_out <= sync_d;
    end
  end

endmodule

// ### inc/abc_frame_if.sv
`timescale 1ns/10ps
// ==========================================================================
// Frame events between the serial engine and the register bank.
// ==========================================================================
interface abc_frame_if;
  logic wr_stb;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport engine (output wr_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

// ### inc/abc_pkg.sv
// ==========================================================================
// Shared constants for the front-end control register bank.
// ==========================================================================
package abc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // Bit counter values at the last command bit and the last frame bit.
  localparam logic [3:0] CNT_CMD_LAST = 4'h6;
  localparam logic [3:0] CNT_FRAME_LAST = 4'he;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Register offsets on the serial port.
  localparam logic [ADDR_W-1:0] OFS_BLOCK = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_CAL = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_OVL = 6'h05;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 6'h09;

  // Reset values.
  localparam logic [DATA_W-1:0] BLOCK_RST = 8'h00;
  localparam logic [DATA_W-1:0] CAL_RST = 8'h00;
  localparam logic [DATA_W-1:0] OVL_RST = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // Writable bits of each register; all other bits keep their reset value.
  localparam logic [DATA_W-1:0] BLOCK_WMASK = 8'h0f;
  localparam logic [DATA_W-1:0] CAL_WMASK = 8'h0f;
  localparam logic [DATA_W-1:0] OVL_WMASK = 8'h60;

  // Field positions.
  localparam int BIT_ZERO_CROSS = 0;
  localparam int BIT_REF_ONE = 1;
  localparam int BIT_REF_TWO = 2;
  localparam int BIT_PA = 3;
  localparam int BIT_TXCAL = 0;
  localparam int BIT_RXCAL = 1;
  localparam int BIT_PGACAL = 2;
  localparam int BIT_BAND = 3;
  localparam int BIT_TXRDY = 6;
  localparam int BIT_RXRDY = 7;
  localparam int BIT_TEN = 5;
  localparam int BIT_IEN = 6;
  localparam int BIT_TFLAG = 5;
  localparam int BIT_IFLAG = 6;
  localparam int KEY_LSB = 2;
  localparam int KEY_MSB = 4;
  localparam logic [2:0] SOFT_RESET_KEY = 3'b101;

  // Order of the inputs in the synchroniser vector.
  localparam int SY_SCLK = 0;
  localparam int SY_CS = 1;
  localparam int SY_MOSI = 2;
  localparam int SY_TXRDY = 3;
  localparam int SY_RXRDY = 4;
  localparam int SY_THERM = 5;
  localparam int SY_OCUR = 6;
  localparam int SY_W = 7;
  localparam logic [SY_W-1:0] SY_RST = 7'h02;

  // Serial frame phases.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_DATA = 2'b10,
    PH_DONE = 2'b11
  } abc_phase_t;

endpackage

// ### tb/abc_host.sv
`timescale 1ns/10ps
// ==========================================================================
// Host serial master model.
// ==========================================================================
module abc_host (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  // Idle bus: select high and the clock parked low between frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Every change lands just after a core clock edge, so no sample races it.
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sends nbits of the frame; fewer than 15 aborts it by raising the select.
  // The low phase is five cycles so that the answer has settled by the rise.
  task automatic frame(input logic rw, input logic [5:0] adr, input logic [7:0] wd, input int nbits,
                       output logic [7:0] rd);
    logic [14:0] sh;
    sh = {rw, adr, wd};
    rd = 8'h00;
    cs_n = 1'b0;
    wait_clk(4);
    for (int i = 0; i < nbits; i++) begin
      mosi = sh[14 - i];
      wait_clk(5);
      sclk = 1'b1;
      rd = {rd[6:0], miso};
      wait_clk(3);
      sclk = 1'b0;
    end
    wait_clk(5);
    cs_n = 1'b1;
    mosi = ~mosi;  // Released data line shows no stale bit.
    wait_clk(4);
  endtask
endmodule

// ### tb/abc_regs_sva.sv
`timescale 1ns/10ps
// ==========================================================================
// Port checker for the control register bank.
// ==========================================================================
module abc_regs_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic thermal_overload_in,
  input wire logic overcurrent_in,
  input wire logic zero_cross_detector_enable,
  input wire logic reference_one_enable,
  input wire logic reference_two_enable,
  input wire logic power_amp_stage_enable,
  input wire logic power_amp_stage_hiz,
  input wire logic tx_calibrate,
  input wire logic rx_calibrate,
  input wire logic transmit_gain_amp_calibrate,
  input wire logic filter_band_select,
  input wire logic thermal_flag,
  input wire logic overcurrent_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Output stage and register updates.
  // ==========================================================================
  property p_pa_on;
    power_amp_stage_enable |-> !power_amp_stage_hiz;
  endproperty
  a_pa_on: assert property (p_pa_on) else $error("stage enabled yet high impedance");
  property p_pa_off;
    !power_amp_stage_enable |-> power_amp_stage_hiz;
  endproperty
  a_pa_off: assert property (p_pa_off) else $error("stage disabled yet driving");
  // Writes only land while a frame holds the select low.
  property p_blk_quiet;
    cs_n [*4] |-> $stable({zero_cross_detector_enable, reference_one_enable, reference_two_enable});
  endproperty
  a_blk_quiet: assert property (p_blk_quiet) else $error("enable moved with no frame");
  property p_cal_cause;
    $changed({tx_calibrate, rx_calibrate, transmit_gain_amp_calibrate, filter_band_select}) |-> !$past(cs_n, 3);
  endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("calibration moved with no frame");

  // ==========================================================================
  // Serial output.
  // ==========================================================================
  property p_oe_on;
    !cs_n [*5] |-> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not enabled in frame");
  property p_oe_off;
    cs_n [*5] |-> !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled outside frame");
  property p_miso_idle;
    !miso_oe |-> !miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("data out moves while disabled");

  // ==========================================================================
  // Overload flags.
  // ==========================================================================
  property p_tflag_cause;
    $rose(thermal_flag) |-> $past(thermal_overload_in, 2) || $past(thermal_overload_in, 3);
  endproperty
  a_tflag_cause: assert property (p_tflag_cause) else $error("thermal flag set without event");
  property p_iflag_cause;
    $rose(overcurrent_flag) |-> $past(overcurrent_in, 2) || $past(overcurrent_in, 3);
  endproperty
  a_iflag_cause: assert property (p_iflag_cause) else $error("current flag set without event");
  property p_flag_clr;
    $fell(thermal_flag) || $fell(overcurrent_flag) |-> !$past(cs_n, 3);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag cleared with no frame");

  c_pa: cover property ($rose(power_amp_stage_enable));
  c_tflag: cover property ($rose(thermal_flag));
  c_iclr: cover property ($fell(overcurrent_flag));
endmodule

bind abc_regs abc_regs_sva u_abc_regs_sva (.clk, .arst_n, .cs_n, .miso, .miso_oe, .thermal_overload_in,
  .overcurrent_in, .zero_cross_detector_enable, .reference_one_enable, .reference_two_enable,
  .power_amp_stage_enable, .power_amp_stage_hiz, .tx_calibrate, .rx_calibrate,
  .transmit_gain_amp_calibrate, .filter_band_select, .thermal_flag, .overcurrent_flag);

// ### tb/abc_regs_tb.sv
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the control register bank.
// ==========================================================================
module abc_regs_tb
  import abc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, sclk, cs_n, mosi, miso, miso_oe;
  logic tx_ready_in = 1'b0, rx_ready_in = 1'b0, thermal_overload_in = 1'b0, overcurrent_in = 1'b0;
  logic zero_cross_detector_enable, reference_one_enable, reference_two_enable, power_amp_stage_enable;
  logic power_amp_stage_hiz, tx_calibrate, rx_calibrate, transmit_gain_amp_calibrate, filter_band_select;
  logic thermal_flag, overcurrent_flag;
  logic [3:0] blk, cal;
  int fails = 0;
  int num_checks = 0;

  // Outputs packed in register bit order for compact comparisons.
  assign blk = {power_amp_stage_enable, reference_two_enable, reference_one_enable, zero_cross_detector_enable};
  assign cal = {filter_band_select, transmit_gain_amp_calibrate, rx_calibrate, tx_calibrate};

  always #50 clk = ~clk;

  abc_regs u_abc_regs (.clk, .arst_n, .sclk, .cs_n, .mosi, .miso, .miso_oe, .tx_ready_in, .rx_ready_in,
    .thermal_overload_in, .overcurrent_in, .zero_cross_detector_enable, .reference_one_enable,
    .reference_two_enable, .power_amp_stage_enable, .power_amp_stage_hiz, .tx_calibrate, .rx_calibrate,
    .transmit_gain_amp_calibrate, .filter_band_select, .thermal_flag, .overcurrent_flag);
  abc_host u_abc_host (.clk, .miso, .sclk, .cs_n, .mosi);

  // ==========================================================================
  // Tasks.
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_abc_host.frame(1'b0, a, d, 15, r);
  endtask

  // Read frames carry junk data on purpose; it must be ignored.
  task automatic rd(input logic [5:0] a, output logic [7:0] r);
    u_abc_host.frame(1'b1, a, 8'h5a, 15, r);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd(a, r);
    check(r, exp);
  endtask

  task automatic pulse(input logic t, input logic o);
    thermal_overload_in = t;
    overcurrent_in = o;
    u_abc_host.wait_clk(6);
    thermal_overload_in = 1'b0;
    overcurrent_in = 1'b0;
    u_abc_host.wait_clk(4);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  initial begin
    logic [7:0] r;
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    u_abc_host.wait_clk(4);
    check({3'h0, power_amp_stage_hiz, blk}, 8'h10);
    check({4'h0, cal}, 8'h00);
    rd_chk(OFS_BLOCK, 8'h00);
    rd_chk(OFS_CAL, 8'h00);
    rd(OFS_OVL, r);
    check(r & 8'h7f, 8'h01);
    $display("test reset finished");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BLOCK, 8'hf0 | (8'h01 << i));
      check({3'h0, power_amp_stage_hiz, blk}, {3'h0, i != 3, 4'h1 << i});
      rd_chk(OFS_BLOCK, 8'h01 << i);
      tx_ready_in = i[0];
      rx_ready_in = !i[0];
      wr(OFS_CAL, 8'hf0 | (8'h01 << i));
      check({4'h0, cal}, {4'h0, 4'h1 << i});
      rd_chk(OFS_CAL, {!i[0], i[0], 2'b00, 4'h1 << i});
    end
    $display("test enables finished");
    wr(OFS_OVL, 8'hff);
    rd(OFS_OVL, r);
    check(r & 8'h7f, 8'h61);
    pulse(1'b1, 1'b0);
    check({6'h0, overcurrent_flag, thermal_flag}, 8'h01);
    pulse(1'b0, 1'b1);
    rd_chk(OFS_FLAGS, 8'h60);
    wr(OFS_FLAGS, 8'h40);
    check({6'h0, overcurrent_flag, thermal_flag}, 8'h02);
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_OVL, 8'h00);
    pulse(1'b1, 1'b1);
    check({6'h0, overcurrent_flag, thermal_flag}, 8'h00);
    $display("test flags finished");
    wr(OFS_BLOCK, 8'h0f);
    wr(OFS_CAL, 8'h0a);
    wr(OFS_OVL, 8'h60);
    wr(OFS_FLAGS, 8'h14);
    check({3'h0, power_amp_stage_hiz, blk}, 8'h10);
    rd_chk(OFS_CAL, {rx_ready_in, tx_ready_in, 6'h0a});
    rd(OFS_OVL, r);
    check(r & 8'h7f, 8'h01);
    $display("test soft reset finished");
    u_abc_host.frame(1'b0, OFS_BLOCK, 8'h07, 12, r);
    rd_chk(OFS_BLOCK, 8'h00);
    wr(6'h3f, 8'hff);
    rd_chk(6'h3f, 8'h00);
    rd_chk(OFS_BLOCK, 8'h00);
    $display("test framing finished");
    complete_run();
  end

  // Whole sequence needs roughly 4800 cycles; four times that means a hang.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
